/* File: hw/adc_input_bias_monitor_regs.sv */
// Bias, monitor select and gain/rate registers behind a byte-wide serial command port
//
// What this block does
// R1 - Bias register at 01h, resets to 00h
// R2 - Bias bit 1 biases negative input
// R3 - Bias bit 0 biases positive input
// R4 - Monitor register 02h; flag undefined, others zero
// R5 - Bit 7 flags external clock in use
// R6 - Bits 2:0 select input; 000 normal
// R7 - Monitor selection overrides bias enables
// R8 - Code 001 shorts inputs to mid-supply
// R9 - Code 010 measures reference, gain one
// R10 - Code 011 selects temperature diode, gain one
// R11 - Normal or offset restores stored gain
// R12 - Register 03h: reserved, gain, rate fields
// R13 - Write: 0100 addr, 0000 count, data
// R14 - Read: 0010 addr, 0000 count, NOPs
// R15 - Read-only and reserved bits ignore writes
`timescale 1ns/1ps
`include "adc_mon_defs.svh"

module adc_input_bias_monitor_regs (
	input  wire logic                    CORE_CLK,
	input  wire logic                    RST,
	input  wire logic [7:0]              CMD_BYTE,
	input  wire logic                    CMD_VALID,
	input  wire logic                    EXT_CLK_IN_USE,
	output logic [7:0]                   RSP_BYTE,
	output logic                         RSP_VALID,
	output logic                         POS_BIAS_EN,
	output logic                         NEG_BIAS_EN,
	output adc_mon_pkg::input_src_e      INPUT_SRC,
	output logic [2:0]                   AMP_GAIN,
	output logic [3:0]                   OUTPUT_RATE_SEL
);

	adc_mon_pkg::cmd_state_e state_r;
	logic [3:0]              addr_r;
	logic [3:0]              count_r;
	logic                    op_write_r;
	logic [1:0]              bias_r;
	logic [2:0]              mon_r;
	logic [2:0]              gain_r;
	logic [3:0]              rate_r;
	logic                    clk_flag_r;
	logic [7:0]              rsp_byte_r;
	logic                    rsp_valid_r;
	logic                    data_byte;
	logic                    wr_en;
	logic                    rd_en;

	// Register image as seen by a read; unmapped and reserved bits read zero
	function automatic logic [7:0] reg_value(input logic [3:0] a, input logic [1:0] b,
		input logic [2:0] m, input logic f, input logic [2:0] g, input logic [3:0] r);
		logic [7:0] v;
		v = 8'h00;
		case (a)
			`BIAS_ADDR: v[`BIAS_NEG_BIT:`BIAS_POS_BIT] = b; // R1
			`MON_ADDR: begin
				v[`MON_HI:`MON_LO] = m; // R6
				v[`CLK_FLAG_BIT]   = f; // R5
			end
			`SYS_ADDR: begin
				v[`GAIN_HI:`GAIN_LO] = g; // R12
				v[`RATE_HI:`RATE_LO] = r; // R12
			end
			default: v = 8'h00;
		endcase
		return v;
	endfunction : reg_value

	// Burst address steps through the 4-bit space and wraps
	function automatic logic [3:0] next_addr(input logic [3:0] a);
		return a + 4'h1;
	endfunction : next_addr

	assign data_byte = CMD_VALID && (state_r == adc_mon_pkg::ST_WDATA || state_r == adc_mon_pkg::ST_RDATA);
	assign wr_en     = CMD_VALID && state_r == adc_mon_pkg::ST_WDATA;
	assign rd_en     = CMD_VALID && state_r == adc_mon_pkg::ST_RDATA;

	// Command parser: opcode byte, count byte, then the data bytes
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			state_r    <= adc_mon_pkg::ST_OPCODE;
			addr_r     <= 4'h0;
			count_r    <= 4'h0;
			op_write_r <= 1'b0;
		end else if (CMD_VALID) begin
			case (state_r)
				adc_mon_pkg::ST_OPCODE: begin
					addr_r <= CMD_BYTE[`NIB_HI:`NIB_LO];
					if (CMD_BYTE[`OPC_HI:`OPC_LO] == `OP_WRITE) begin
						op_write_r <= 1'b1; // R13
						state_r    <= adc_mon_pkg::ST_COUNT;
					end else if (CMD_BYTE[`OPC_HI:`OPC_LO] == `OP_READ) begin
						op_write_r <= 1'b0; // R14
						state_r    <= adc_mon_pkg::ST_COUNT;
					end
				end
				adc_mon_pkg::ST_COUNT: begin
					count_r <= CMD_BYTE[`NIB_HI:`NIB_LO]; // R13 R14
					state_r <= op_write_r ? adc_mon_pkg::ST_WDATA : adc_mon_pkg::ST_RDATA;
				end
				adc_mon_pkg::ST_WDATA, adc_mon_pkg::ST_RDATA: begin
					addr_r <= next_addr(addr_r);
					if (count_r == `COUNT_LAST) begin
						state_r <= adc_mon_pkg::ST_OPCODE;
					end else begin
						count_r <= count_r - 4'h1;
					end
				end
				default: state_r <= adc_mon_pkg::ST_OPCODE;
			endcase
		end
	end

	// Bias enables; upper six bits are not stored so writes cannot change them
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			bias_r <= `BIAS_RST; // R1
		end else if (wr_en && addr_r == `BIAS_ADDR) begin
			bias_r <= CMD_BYTE[`BIAS_NEG_BIT:`BIAS_POS_BIT]; // R2 R3 R15
		end
	end

	// Monitor select field only; the flag bit is never written
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			mon_r <= `MON_RST; // R4
		end else if (wr_en && addr_r == `MON_ADDR) begin
			mon_r <= CMD_BYTE[`MON_HI:`MON_LO]; // R6 R15
		end
	end

	// Gain and rate fields; bit 7 stays reserved
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			gain_r <= `GAIN_RST; // R12
			rate_r <= `RATE_RST; // R12
		end else if (wr_en && addr_r == `SYS_ADDR) begin
			gain_r <= CMD_BYTE[`GAIN_HI:`GAIN_LO];
			rate_r <= CMD_BYTE[`RATE_HI:`RATE_LO];
		end
	end

	// Clock source status has no reset; it simply tracks the clock switch
	always_ff @(posedge CORE_CLK) begin
		clk_flag_r <= EXT_CLK_IN_USE; // R4 R5
	end

	// Read answer: one byte per host byte, incoming content ignored
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			rsp_byte_r  <= 8'h00;
			rsp_valid_r <= 1'b0;
		end else begin
			rsp_valid_r <= rd_en; // R14
			if (rd_en) begin
				rsp_byte_r <= reg_value(addr_r, bias_r, mon_r, clk_flag_r, gain_r, rate_r);
			end
		end
	end

	assign RSP_BYTE        = rsp_byte_r;
	assign RSP_VALID       = rsp_valid_r;
	assign OUTPUT_RATE_SEL = rate_r;

	// Analog routing and gain override
	monitor_route monitor_route_inst (
		.clk                (CORE_CLK),
		.rst                (RST),
		.monitor_select     (mon_r),
		.input_bias_enables (bias_r),
		.amp_gain_stored    (gain_r),
		.input_src          (INPUT_SRC),
		.pos_bias_en        (POS_BIAS_EN),
		.neg_bias_en        (NEG_BIAS_EN),
		.amp_gain           (AMP_GAIN)
	);

	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (RST);

	sequence s_write_opcode;
		CMD_VALID && state_r == adc_mon_pkg::ST_OPCODE && CMD_BYTE[`OPC_HI:`OPC_LO] == `OP_WRITE;
	endsequence

	sequence s_count_byte;
		CMD_VALID && state_r == adc_mon_pkg::ST_COUNT;
	endsequence

	// Back-to-back opcode and count lead into the data phase with the count held
	a_write_entry: assert property (s_write_opcode ##1 s_count_byte // R13
		|=> state_r == adc_mon_pkg::ST_WDATA && count_r == $past(CMD_BYTE[`NIB_HI:`NIB_LO]))
		else $error("write command did not enter data phase");

	// Bias write stores the two low bits at the next edge
	a_bias_write: assert property (wr_en && addr_r == `BIAS_ADDR // R1
		|=> bias_r == $past(CMD_BYTE[`BIAS_NEG_BIT:`BIAS_POS_BIT]))
		else $error("bias register not updated");

	// Every read data byte gets exactly one answer pulse next cycle
	a_read_answer: assert property (rd_en |=> RSP_VALID ##1 !RSP_VALID || $past(rd_en)) // R14
		else $error("read answer missing");

	// Monitor read shows the clock status flag in bit 7
	a_flag_readback: assert property (rd_en && addr_r == `MON_ADDR // R5
		|=> RSP_BYTE[`CLK_FLAG_BIT] == $past(clk_flag_r) && RSP_BYTE[`MON_HI:`MON_LO] == $past(mon_r))
		else $error("monitor readback wrong");

	// Reserved top bit of the gain/rate register always reads zero
	a_sys_reserved: assert property (rd_en && addr_r == `SYS_ADDR |=> !RSP_BYTE[`SYS_RSVD_BIT]) // R12
		else $error("reserved bit read as one");

	// Last data byte returns the parser to opcode wait
	a_burst_end: assert property (data_byte && count_r == `COUNT_LAST |=> state_r == adc_mon_pkg::ST_OPCODE) // R13
		else $error("burst did not end");

endmodule : adc_input_bias_monitor_regs

/* File: hw/adc_mon_defs.svh */
// Register offsets, field positions, reset values and command codes of the monitor register bank
`ifndef ADC_MON_DEFS_SVH
`define ADC_MON_DEFS_SVH

// Register offsets (4-bit address nibble of the command byte)
`define BIAS_ADDR     4'h1
`define MON_ADDR      4'h2
`define SYS_ADDR      4'h3

// Command opcodes in the upper nibble of the first command byte
`define OP_WRITE      4'h4
`define OP_READ       4'h2

// Field positions
`define BIAS_NEG_BIT  1
`define BIAS_POS_BIT  0
`define CLK_FLAG_BIT  7
`define SYS_RSVD_BIT  7
`define MON_HI        2
`define MON_LO        0
`define GAIN_HI       6
`define GAIN_LO       4
`define RATE_HI       3
`define RATE_LO       0
`define NIB_HI        3
`define NIB_LO        0
`define OPC_HI        7
`define OPC_LO        4

// Reset values of the writable fields
`define BIAS_RST      2'h0
`define MON_RST       3'h0
`define GAIN_RST      3'h0
`define RATE_RST      4'h0

// Monitor select codes
`define MON_NORMAL    3'h0
`define MON_OFFSET    3'h1
`define MON_GAINCAL   3'h2
`define MON_TEMP      3'h3

// Gain code that means a gain of one
`define GAIN_UNITY    3'h0

// Last byte of a burst is reached when the remaining count is this
`define COUNT_LAST    4'h0

`endif

/* File: hw/adc_mon_pkg.sv */
// Types shared by the monitor register bank and its input routing stage
package adc_mon_pkg;

	// Serial command parser states
	typedef enum logic [1:0] {
		ST_OPCODE,
		ST_COUNT,
		ST_WDATA,
		ST_RDATA
	} cmd_state_e;

	// Where the converter input is connected
	typedef enum logic [1:0] {
		SRC_EXTERNAL,
		SRC_MID_SUPPLY,
		SRC_REFERENCE,
		SRC_TEMP_DIODE
	} input_src_e;

endpackage : adc_mon_pkg

/* File: hw/monitor_route.sv */
// Input routing, bias gating and gain override driven by the monitor select field
`timescale 1ns/1ps
`include "adc_mon_defs.svh"

module monitor_route (
	input  wire logic                    clk,
	input  wire logic                    rst,
	input  wire logic [2:0]              monitor_select,
	input  wire logic [1:0]              input_bias_enables,
	input  wire logic [2:0]              amp_gain_stored,
	output adc_mon_pkg::input_src_e      input_src,
	output logic                         pos_bias_en,
	output logic                         neg_bias_en,
	output logic [2:0]                   amp_gain
);

	adc_mon_pkg::input_src_e src_nxt;
	logic                    force_unity;
	logic                    bias_allowed;

	// Decode the selection; reserved codes fall back to normal routing
	always_comb begin
		force_unity  = 1'b0;
		bias_allowed = 1'b0;
		case (monitor_select)
			`MON_NORMAL: begin
				src_nxt      = adc_mon_pkg::SRC_EXTERNAL;
				bias_allowed = 1'b1;
			end
			`MON_OFFSET: begin
				src_nxt = adc_mon_pkg::SRC_MID_SUPPLY; // R8
			end
			`MON_GAINCAL: begin
				src_nxt     = adc_mon_pkg::SRC_REFERENCE; // R9
				force_unity = 1'b1; // R9
			end
			`MON_TEMP: begin
				src_nxt     = adc_mon_pkg::SRC_TEMP_DIODE; // R10
				force_unity = 1'b1; // R10
			end
			default: begin
				src_nxt      = adc_mon_pkg::SRC_EXTERNAL;
				bias_allowed = 1'b1;
			end
		endcase
	end

	// Registered analog controls; bias only applies with no monitor active
	always_ff @(posedge clk) begin
		if (rst) begin
			input_src   <= adc_mon_pkg::SRC_EXTERNAL;
			pos_bias_en <= 1'b0;
			neg_bias_en <= 1'b0;
			amp_gain    <= `GAIN_RST;
		end else begin
			input_src   <= src_nxt;
			pos_bias_en <= bias_allowed & input_bias_enables[`BIAS_POS_BIT]; // R3 R7
			neg_bias_en <= bias_allowed & input_bias_enables[`BIAS_NEG_BIT]; // R2 R7
			amp_gain    <= force_unity ? `GAIN_UNITY : amp_gain_stored; // R9 R10 R11
		end
	end

	// Calibration and temperature modes hold the gain at one
	a_gain_forced: assert property (@(posedge clk) disable iff (rst) // R9
		(monitor_select == `MON_GAINCAL || monitor_select == `MON_TEMP) |=> amp_gain == `GAIN_UNITY)
		else $error("gain not forced to unity in monitor mode");

	// Normal and offset modes use the stored gain
	a_gain_restore: assert property (@(posedge clk) disable iff (rst) // R11
		(monitor_select == `MON_NORMAL || monitor_select == `MON_OFFSET)
			|=> amp_gain == $past(amp_gain_stored))
		else $error("stored gain not restored");

	// Any monitor selection masks both bias enables
	a_bias_override: assert property (@(posedge clk) disable iff (rst) // R7
		(monitor_select inside {`MON_OFFSET, `MON_GAINCAL, `MON_TEMP}) |=> !pos_bias_en && !neg_bias_en)
		else $error("bias applied while monitor selected");

endmodule : monitor_route

/* File: testbench/host_cmd_model.sv */
// Host controller model issuing register commands over the byte port
`timescale 1ns/1ps
module host_cmd_model (
	input  wire logic       clk,
	input  wire logic [7:0] rsp_byte,
	input  wire logic       rsp_valid,
	output logic [7:0]      cmd_byte,
	output logic            cmd_valid
);
	initial begin
		cmd_byte = 8'hff;
		cmd_valid = 1'b0;
	end
	// One byte per cycle, launched off the falling edge
	task automatic put(input logic [7:0] b);
		@(negedge clk);
		cmd_byte = b;
		cmd_valid = 1'b1;
	endtask : put
	// Released lines show the inverse so stale data is never taken as fresh
	task automatic idle();
		@(negedge clk);
		cmd_valid = 1'b0;
		cmd_byte = ~cmd_byte;
	endtask : idle
	// Opcode with start address, count minus one, then data back to back
	task automatic wr(input logic [3:0] a, input logic [7:0] d[$]);
		put({4'h4, a});
		put({4'h0, 4'(d.size() - 1)});
		foreach (d[i]) put(d[i]);
		idle();
	endtask : wr
	// A gap after each filler byte keeps answers apart; wait is bounded
	// The answer pulse lasts one cycle, so the release edge itself is the first look
	task automatic rd(input logic [3:0] a, input int n, output logic [7:0] q[$]);
		q = {};
		put({4'h2, a});
		put({4'h0, 4'(n - 1)});
		repeat (n) begin
			put(8'hff);
			for (int k = 0; k < 4; k++) begin
				if (k == 0) begin
					idle();
				end else begin
					@(negedge clk);
				end
				if (rsp_valid === 1'b1) begin
					q.push_back(rsp_byte);
					break;
				end
			end
		end
	endtask : rd
endmodule : host_cmd_model

/* File: testbench/test_adc_input_bias_monitor_regs.sv */
// Self-checking bench for the bias, monitor select and gain/rate register bank
`timescale 1ns/1ps
`include "adc_mon_defs.svh"
module test_adc_input_bias_monitor_regs;
	logic                    clk;
	logic                    rst;
	logic                    ext;
	logic [7:0]              cmd;
	logic                    cmd_v;
	logic [7:0]              rsp;
	logic                    rsp_v;
	logic                    pos;
	logic                    neg;
	adc_mon_pkg::input_src_e src;
	logic [2:0]              gain;
	logic [3:0]              rate;
	logic [7:0]              q[$];
	int                      err_count;
	int                      checks_done;

	// 200 MHz core clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	adc_input_bias_monitor_regs adc_input_bias_monitor_regs_inst (
		.CORE_CLK(clk), .RST(rst), .CMD_BYTE(cmd), .CMD_VALID(cmd_v), .EXT_CLK_IN_USE(ext),
		.RSP_BYTE(rsp), .RSP_VALID(rsp_v), .POS_BIAS_EN(pos), .NEG_BIAS_EN(neg),
		.INPUT_SRC(src), .AMP_GAIN(gain), .OUTPUT_RATE_SEL(rate)
	);
	host_cmd_model host_cmd_model_inst (
		.clk(clk), .rsp_byte(rsp), .rsp_valid(rsp_v), .cmd_byte(cmd), .cmd_valid(cmd_v)
	);

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic wrap_up();
		$display("Checks %0d, mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : wrap_up

	// Reset contents read as one burst, plus the routed outputs
	task automatic t_reset();
		host_cmd_model_inst.rd(4'h1, 3, q);
		chk(8'(q.size()), 8'h03);
		chk(q[0], 8'h00);
		chk(q[1], 8'h00);
		chk(q[2], 8'h00);
		chk({5'h00, pos, neg, 1'b0}, 8'h00);
		chk({6'h00, src}, 8'h00);
		chk({1'b0, gain, rate}, 8'h00);
	endtask : t_reset

	// Every bias pattern, with reserved bits written high
	task automatic t_bias();
		for (int v = 0; v < 4; v++) begin
			host_cmd_model_inst.wr(4'h1, '{8'(v) | 8'hfc});
			@(negedge clk);
			chk({6'h00, pos, neg}, {6'h00, 1'(v), 1'(v >> 1)});
			host_cmd_model_inst.rd(4'h1, 1, q);
			chk(q[0], 8'(v));
		end
	endtask : t_bias

	// Documented codes only, ordered so each forced gain is left again
	task automatic t_monitor();
		logic [2:0] seq[5];
		seq = '{`MON_GAINCAL, `MON_OFFSET, `MON_TEMP, `MON_NORMAL, `MON_OFFSET};
		host_cmd_model_inst.wr(4'h1, '{8'h03});
		host_cmd_model_inst.wr(4'h3, '{8'h57});
		foreach (seq[i]) begin
			host_cmd_model_inst.wr(4'h2, '{{5'h00, seq[i]}});
			@(negedge clk);
			chk({6'h00, src}, {5'h00, seq[i]});
			chk({5'h00, gain}, {5'h00, (seq[i] >= `MON_GAINCAL) ? `GAIN_UNITY : 3'h5});
			chk({6'h00, pos, neg}, (seq[i] == `MON_NORMAL) ? 8'h03 : 8'h00);
			chk({4'h0, rate}, 8'h07);
		end
		host_cmd_model_inst.rd(4'h3, 1, q);
		chk(q[0], 8'h57);
	endtask : t_monitor

	// Clock flag follows its source and ignores writes
	task automatic t_flag();
		@(negedge clk);
		ext = 1'b1;
		host_cmd_model_inst.wr(4'h2, '{8'h78});
		host_cmd_model_inst.rd(4'h2, 1, q);
		chk(q[0], 8'h80);
		ext = 1'b0;
		host_cmd_model_inst.rd(4'h2, 1, q);
		chk(q[0], 8'h00);
	endtask : t_flag

	// Reserved top bit of the gain/rate register stays zero
	task automatic t_sys();
		host_cmd_model_inst.wr(4'h3, '{8'hd6});
		@(negedge clk);
		chk({1'b0, gain, rate}, 8'h56);
		host_cmd_model_inst.rd(4'h3, 1, q);
		chk(q[0], 8'h56);
	endtask : t_sys

	// Burst through unmapped places with address wrap; stray opcode dropped
	task automatic t_wrap();
		host_cmd_model_inst.wr(4'hf, '{8'haa, 8'h11, 8'h02});
		host_cmd_model_inst.put(8'h13);
		host_cmd_model_inst.idle();
		host_cmd_model_inst.rd(4'hf, 3, q);
		chk(q[0], 8'h00);
		chk(q[1], 8'h00);
		chk(q[2], 8'h02);
	endtask : t_wrap

	initial begin
		rst = 1'b1;
		ext = 1'b0;
		err_count = 0;
		checks_done = 0;
		repeat (4) @(negedge clk);
		rst = 1'b0;
		t_reset();
		t_bias();
		t_monitor();
		t_flag();
		t_sys();
		t_wrap();
		wrap_up();
	end

	// Watchdog far beyond the roughly 120 cycles the tests need
	initial begin
		#200000;
		err_count++;
		wrap_up();
	end
endmodule : test_adc_input_bias_monitor_regs
